// ===== pgx_port.v
`timescale 1ns/10ps
`include "pgx_defs.vh"

// Function
// - Pull-up disable 0: pull-ups on digital non-push-pull pins; 1: all off.
// - Crossbar enable bit turns the crossbar on or off.
// - Control bits 5..3 read zero, writes ignored.
// - Timer 1 input route bit makes it available at a pin.
// - Timer 0 input route bit makes it available at a pin.
// - Counter array clock route bit makes it available at a pin.
// - Port data register supports byte and single-bit access.
// - Writes land in an output latch that holds until rewritten.
// - Ordinary port reads return pin levels, even for peripheral pins.
// - Read-modify-write uses the latch value, not the pins.
// - Latch 0 drives low; 1 drives high if push-pull, else released.
// - Analog pins read as 1; digital pins read actual level.
// - Analog pin: pull-up, driver and receiver all disabled.
// - Input-mode 1 makes the pin a digital input, one bit per pin.
// - Output-mode bit ignored while the pin is analog.
// - Output-mode 0 is open-drain, 1 is push-pull.
// - Serial bus data and clock pins always drive open-drain.
// - Crossbar disabled: every pin is an input, driver off.
// - Pull-up off on an open-drain pin actively driving low.
module pgx_port #(
    parameter N = 8
) (
    input  wire         i_mclk,        // 25 MHz system clock
    input  wire         i_nrst,        // Async reset, active low
    input  wire [7:0]   i_addr,        // Register address
    input  wire         i_wr,          // Write strobe, one cycle
    input  wire         i_rd,          // Read strobe, one cycle
    input  wire         i_rmw,         // Read side of read-modify-write
    input  wire         i_bit_op,      // Single-bit access
    input  wire [2:0]   i_bit_sel,     // Bit index for bit access
    input  wire [7:0]   i_wdata,       // Write data (bit 0 for bit op)
    output reg  [7:0]   o_rdata,       // Read data, valid cycle after rd
    input  wire [N-1:0] i_pin,         // Pin levels from pads
    input  wire [N-1:0] i_periph_sel,  // Pin assigned to a peripheral
    input  wire [N-1:0] i_periph_out,  // Peripheral output value
    input  wire [N-1:0] i_serial_pin,  // Pin carries SDA or SCL
    output reg  [N-1:0] o_pin_out,     // Pad output value
    output reg  [N-1:0] o_pin_oe_n,    // Pad output enable, low drives
    output reg  [N-1:0] o_pullup_en,   // Weak pull-up enable
    output reg  [N-1:0] o_rx_en,       // Digital receiver enable
    output reg          o_xbar_en,     // Crossbar enabled
    output reg          o_timer1_ext_input_en,  // Timer 1 input routed
    output reg          o_timer0_ext_input_en,  // Timer 0 input routed
    output reg          o_counter_array_ext_clock_en // Counter clk routed
);
    // -----------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------
    reg rst_m_q;
    reg rst_q;

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end

    // -----------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------
    wire [N-1:0] pin_s;

    pgx_sync #(
        .W(N)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_q),
        .i_async (i_pin),
        .o_sync  (pin_s)
    );

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    reg  [7:0]   port_data_latch_q;
    reg  [7:0]   crossbar_control_q;
    reg  [7:0]   pin_input_mode_q;
    reg  [7:0]   pin_output_mode_q;
    reg  [7:0]   port_wval;

    wire sel_port = (i_addr == `PGX_ADDR_PORT_DATA);
    wire sel_xc   = (i_addr == `PGX_ADDR_XBAR_CTRL);
    wire sel_in   = (i_addr == `PGX_ADDR_IN_MODE);
    wire sel_out  = (i_addr == `PGX_ADDR_OUT_MODE);

    // Bit writes merge into the latch, so other pins keep their value
    always @* begin
        port_wval = i_wdata;
        if (i_bit_op) begin
            port_wval = port_data_latch_q;
            port_wval[i_bit_sel] = i_wdata[0];
        end
    end

    always @(posedge i_mclk or negedge rst_q) begin
        if (!rst_q) begin
            port_data_latch_q  <= `PGX_RST_PORT_DATA;
            crossbar_control_q <= `PGX_RST_XBAR_CTRL;
            pin_input_mode_q   <= `PGX_RST_IN_MODE;
            pin_output_mode_q  <= `PGX_RST_OUT_MODE;
        end else if (i_wr) begin
            if (sel_port)
                port_data_latch_q <= port_wval;
            if (sel_xc)
                crossbar_control_q <= i_wdata & `PGX_XC_WMASK;
            if (sel_in)
                pin_input_mode_q <= i_wdata;
            if (sel_out)
                pin_output_mode_q <= i_wdata;
        end
    end

    // -----------------------------------------------------------
    // Read path
    // -----------------------------------------------------------
    reg  [7:0] pin_view;
    reg  [7:0] rd_d;

    always @* begin
        pin_view = 8'h00;
        pin_view[N-1:0] = pin_s | ~pin_input_mode_q[N-1:0];
        rd_d = 8'h00;
        if (sel_port)
            rd_d = i_rmw ? port_data_latch_q : pin_view;
        else if (sel_xc)
            rd_d = crossbar_control_q;
        else if (sel_in)
            rd_d = pin_input_mode_q;
        else if (sel_out)
            rd_d = pin_output_mode_q;
        if (i_bit_op)
            rd_d = {7'h00, rd_d[i_bit_sel]};
    end

    always @(posedge i_mclk or negedge rst_q) begin
        if (!rst_q)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rd_d;
    end

    // -----------------------------------------------------------
    // Pad control, one cell per pin
    // -----------------------------------------------------------
    wire xbar_en = crossbar_control_q[`PGX_XC_XBAR_EN];
    wire pu_dis  = crossbar_control_q[`PGX_XC_PULLUP_DIS];

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_pin
            wire dig  = pin_input_mode_q[g];
            wire pp   = pin_output_mode_q[g] & dig
                        & ~i_serial_pin[g];
            wire val  = i_periph_sel[g] ? i_periph_out[g]
                                        : port_data_latch_q[g];
            // Open-drain releases on 1; push-pull drives both levels
            wire drv  = xbar_en & dig
                        & (pp | ~val);
            wire drv_low = drv & ~val;

            always @(posedge i_mclk or negedge rst_q) begin
                if (!rst_q) begin
                    o_pin_out[g]   <= 1'b1;
                    o_pin_oe_n[g]  <= 1'b1;
                    o_pullup_en[g] <= 1'b0;
                    o_rx_en[g]     <= 1'b0;
                end else begin
                    o_pin_out[g]   <= val;
                    o_pin_oe_n[g]  <= ~drv;
                    o_pullup_en[g] <= dig & ~pu_dis & ~pp
                                      & ~drv_low;
                    o_rx_en[g]     <= dig;
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------
    // Routing enables toward the crossbar decoder
    // -----------------------------------------------------------
    always @(posedge i_mclk or negedge rst_q) begin
        if (!rst_q) begin
            o_xbar_en                    <= 1'b0;
            o_timer1_ext_input_en        <= 1'b0;
            o_timer0_ext_input_en        <= 1'b0;
            o_counter_array_ext_clock_en <= 1'b0;
        end else begin
            o_xbar_en <= xbar_en;
            o_timer1_ext_input_en <=
                crossbar_control_q[`PGX_XC_T1_EN];
            o_timer0_ext_input_en <=
                crossbar_control_q[`PGX_XC_T0_EN];
            o_counter_array_ext_clock_en <=
                crossbar_control_q[`PGX_XC_ECI_EN];
        end
    end
endmodule // pgx_port

// ===== pgx_defs.vh
`ifndef PGX_DEFS_VH
`define PGX_DEFS_VH
// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define PGX_ADDR_PORT_DATA   8'h80
`define PGX_ADDR_XBAR_CTRL   8'hE3
`define PGX_ADDR_IN_MODE     8'hF1
`define PGX_ADDR_OUT_MODE    8'hA4
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PGX_RST_PORT_DATA    8'hFF
`define PGX_RST_XBAR_CTRL    8'h00
`define PGX_RST_IN_MODE      8'hFF
`define PGX_RST_OUT_MODE     8'h00
// ---------------------------------------------------------------
// Crossbar control fields
// ---------------------------------------------------------------
`define PGX_XC_PULLUP_DIS    7
`define PGX_XC_XBAR_EN       6
`define PGX_XC_T1_EN         2
`define PGX_XC_T0_EN         1
`define PGX_XC_ECI_EN        0
`define PGX_XC_WMASK         8'hC7
`endif

// ===== pgx_sync.v
`timescale 1ns/10ps
// Two-flop synchroniser, one per bit
module pgx_sync #(
    parameter W = 8
) (
    input  wire         i_mclk,   // System clock
    input  wire         i_rst_n,  // Synchronised reset
    input  wire [W-1:0] i_async,  // Asynchronous level
    output reg  [W-1:0] o_sync    // Synchronised level
);
    reg [W-1:0] meta_q;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // pgx_sync

// ===== pgx_port_properties.sv
`timescale 1ns/10ps
module pgx_port_properties #(
    parameter N = 8
) (
    input logic         i_mclk,
    input logic         i_nrst,
    input logic [7:0]   i_addr,
    input logic         i_wr,
    input logic         i_rd,
    input logic         i_rmw,
    input logic         i_bit_op,
    input logic [7:0]   i_wdata,
    input logic [N-1:0] i_serial_pin,
    input logic [7:0]   o_rdata,
    input logic [N-1:0] o_pin_out,
    input logic [N-1:0] o_pin_oe_n,
    input logic [N-1:0] o_pullup_en,
    input logic [N-1:0] o_rx_en,
    input logic         o_xbar_en,
    input logic         o_timer1_ext_input_en,
    input logic         o_timer0_ext_input_en,
    input logic         o_counter_array_ext_clock_en
);
    logic [7:0] wd_q1;
    logic [7:0] wd_q2;
    logic [7:0] wd_q3;
    // Write data delayed to line up with later pad and read-back updates
    always_ff @(posedge i_mclk) begin
        wd_q1 <= i_wdata;
        wd_q2 <= wd_q1;
        wd_q3 <= wd_q2;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_ctrl_hold;
        i_wr && !i_bit_op && i_addr == 8'hE3
        ##1 !(i_wr && i_addr == 8'hE3);
    endsequence
    sequence s_port_wr_rmw;
        i_wr && !i_bit_op && i_addr == 8'h80
        ##1 !i_wr ##1 i_rd && i_rmw && !i_bit_op && i_addr == 8'h80;
    endsequence
    AST_RSV_ZERO: assert property (
        i_rd && !i_bit_op && i_addr == 8'hE3 |=> o_rdata[5:3] == 3'h0)
        else $error("reserved control bits read nonzero");
    AST_XBAR_OFF: assert property (
        !o_xbar_en && !$past(o_xbar_en) |-> &o_pin_oe_n)
        else $error("pin driven while crossbar off");
    AST_NO_PULL_DRV: assert property (
        !(|(o_pullup_en & ~o_pin_oe_n)))
        else $error("pull-up on a driven pin");
    AST_SERIAL_OD: assert property (
        $stable(i_serial_pin) |-> !(|(i_serial_pin & o_pin_out & ~o_pin_oe_n)))
        else $error("serial pin driven high");
    AST_ANALOG_OFF: assert property (
        !(|(~o_rx_en & (o_pullup_en | ~o_pin_oe_n))))
        else $error("analog pin has pull-up or driver");
    AST_PULL_DIS: assert property (
        s_ctrl_hold ##0 wd_q1[7] |=> !(|o_pullup_en))
        else $error("pull-ups stay on when disabled");
    AST_CTRL_EN: assert property (
        s_ctrl_hold |=> {o_xbar_en, o_timer1_ext_input_en,
        o_timer0_ext_input_en, o_counter_array_ext_clock_en}
        == {wd_q2[6], wd_q2[2:0]})
        else $error("control enables do not follow write");
    AST_RMW_LATCH: assert property (
        s_port_wr_rmw |=> o_rdata == wd_q3)
        else $error("latch read differs from write");
endmodule // pgx_port_properties

bind pgx_port pgx_port_properties #(.N(N)) i_pgx_port_properties (
    .i_mclk, .i_nrst, .i_addr, .i_wr, .i_rd, .i_rmw, .i_bit_op, .i_wdata,
    .i_serial_pin, .o_rdata, .o_pin_out, .o_pin_oe_n, .o_pullup_en,
    .o_rx_en, .o_xbar_en, .o_timer1_ext_input_en, .o_timer0_ext_input_en,
    .o_counter_array_ext_clock_en);

// ===== pgx_pads.sv
`timescale 1ns/10ps
module pgx_pads (
    input  logic       i_mclk,     // Clock
    input  logic [7:0] i_pin_out,  // Device drive value
    input  logic [7:0] i_oe_n,     // Device drive enable, low
    input  logic [7:0] i_pullup,   // Weak pull-up on
    input  logic [7:0] i_ext_drv,  // Board drives the pin
    input  logic [7:0] i_ext_val,  // Board drive value
    output logic [7:0] o_level     // Resolved pin level
);
    logic [7:0] flt_q = 8'h55;
    // A floating pin wanders so no test can lean on a stale level
    always @(posedge i_mclk) flt_q <= ~flt_q;
    assign o_level = (~i_oe_n & i_pin_out) | (i_oe_n & i_ext_drv & i_ext_val)
                   | (i_oe_n & ~i_ext_drv & (i_pullup | flt_q));
endmodule // pgx_pads

// ===== pgx_port_tb.sv
`timescale 1ns/10ps
module pgx_port_tb;
    logic i_mclk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_rmw = 0;
    logic i_bit_op = 0;
    logic [2:0] i_bit_sel = 3'h0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_periph_sel = 8'h00;
    logic [7:0] i_periph_out = 8'h00, i_serial_pin = 8'h00;
    logic [7:0] ext_drv = 8'h00, ext_val = 8'h00;
    logic [7:0] i_pin, o_rdata, o_pin_out, o_pin_oe_n, o_pullup_en, o_rx_en;
    logic o_xbar_en, o_timer1_ext_input_en, o_timer0_ext_input_en;
    logic o_counter_array_ext_clock_en;
    int failures = 0, comparisons = 0;
    pgx_port i_pgx_port (.i_mclk, .i_nrst, .i_addr, .i_wr, .i_rd, .i_rmw,
        .i_bit_op, .i_bit_sel, .i_wdata, .o_rdata, .i_pin, .i_periph_sel,
        .i_periph_out, .i_serial_pin, .o_pin_out, .o_pin_oe_n, .o_pullup_en,
        .o_rx_en, .o_xbar_en, .o_timer1_ext_input_en, .o_timer0_ext_input_en,
        .o_counter_array_ext_clock_en);
    pgx_pads i_pgx_pads (.i_mclk, .i_pin_out(o_pin_out), .i_oe_n(o_pin_oe_n),
        .i_pullup(o_pullup_en), .i_ext_drv(ext_drv), .i_ext_val(ext_val),
        .o_level(i_pin));
    initial forever #20 i_mclk = ~i_mclk;
    task close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // One idle edge first, so a strobe is never lowered and raised at once
    task wr(input logic [7:0] a, d, input logic b = 0, input logic [2:0] s = 0);
        cyc(1);
        {i_wr, i_bit_op, i_bit_sel, i_addr, i_wdata} = {1'b1, b, s, a, d};
        cyc(1);
        {i_wr, i_bit_op} = 2'b00;
    endtask
    task rc(input logic [7:0] a, input logic m, input logic [7:0] e);
        cyc(1);
        {i_rd, i_rmw, i_addr} = {1'b1, m, a};
        cyc(1);
        {i_rd, i_rmw} = 2'b00;
        chk(o_rdata, e);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rc(8'hE3, 0, 8'h00);
        rc(8'hF1, 0, 8'hFF);
        rc(8'hA4, 0, 8'h00);
        rc(8'h55, 0, 8'h00);
        rc(8'h80, 1, 8'hFF);
        rc(8'h80, 0, 8'hFF);
        chk(o_pin_oe_n, 8'hFF);
        chk(o_pullup_en, 8'hFF);
    endtask
    task t_ctrl;
        wr(8'hE3, 8'hFF);
        rc(8'hE3, 0, 8'hC7);
        chk({4'h0, o_xbar_en, o_timer1_ext_input_en, o_timer0_ext_input_en,
            o_counter_array_ext_clock_en}, 8'h0F);
        chk(o_pullup_en, 8'h00);
        wr(8'hE3, 8'h00);
        cyc(1);
        chk({4'h0, o_xbar_en, o_timer1_ext_input_en, o_timer0_ext_input_en,
            o_counter_array_ext_clock_en}, 8'h00);
        chk(o_pullup_en, 8'hFF);
    endtask
    task t_drive;
        wr(8'hA4, 8'h0F);
        wr(8'hE3, 8'h40);
        wr(8'h80, 8'hA5);
        rc(8'h80, 1, 8'hA5);
        cyc(1);
        chk(o_pin_oe_n, 8'hA0);
        chk(o_pin_out & ~o_pin_oe_n, 8'h05);
        chk(o_pullup_en, 8'hA0);
        {ext_drv, ext_val} = {8'h80, 8'h00};
        cyc(4);
        rc(8'h80, 0, 8'h25);
        rc(8'h80, 1, 8'hA5);
        wr(8'h80, 8'h01, 1, 3'h1);
        rc(8'h80, 1, 8'hA7);
    endtask
    task t_analog;
        wr(8'hF1, 8'h0F);
        wr(8'hA4, 8'hFF);
        ext_drv = 8'hF0;
        cyc(4);
        chk(o_rx_en, 8'h0F);
        chk(o_pin_oe_n & 8'hF0, 8'hF0);
        chk(o_pullup_en, 8'h00);
        rc(8'h80, 0, 8'hF7);
        ext_drv = 8'h00;
        wr(8'hF1, 8'hFF);
    endtask
    task t_serial;
        {i_serial_pin, i_periph_sel, i_periph_out} = {8'h01, 8'h02, 8'h00};
        cyc(2);
        chk({7'h00, o_pin_oe_n[0]}, 8'h01);
        chk({6'h00, o_pin_oe_n[1], o_pin_out[1]}, 8'h00);
        {i_serial_pin, i_periph_sel} = 16'h0000;
        wr(8'hE3, 8'h00);
        cyc(1);
        chk(o_pin_oe_n, 8'hFF);
    endtask
    initial begin
        cyc(4);
        i_nrst = 1;
        cyc(4);
        t_reset;
        t_ctrl;
        t_drive;
        t_analog;
        t_serial;
        close_out;
    end
    initial begin
        #20000;
        failures++;
        close_out;
    end
endmodule // pgx_port_tb
